// >>> cmag_top.sv
// Program and data address generation with bank selection.
`timescale 1ns/10ps
`default_nettype none
module cmag_top (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Mode and bank control writes.
	input wire logic sbs_wr,
	input wire logic [3:0] sbs_wdata,
	input wire logic mbe_wr,
	input wire logic mbe_wdata,
	input wire logic mbs_wr,
	input wire logic [3:0] mbs_wdata,
	// Register pair file.
	input wire logic rp_wr,
	input wire logic [2:0] rp_wsel,
	input wire logic [7:0] rp_wdata,
	input wire logic [2:0] rp_rsel,
	// Program address requests.
	input wire logic pa_req,
	input wire cmag_pkg::cmag_pkind_t pa_kind,
	input wire logic [14:0] pa_operand,
	// Data memory requests.
	input wire logic da_req,
	input wire cmag_pkg::cmag_dkind_t da_kind,
	input wire logic da_we,
	input wire logic [11:0] da_operand,
	input wire logic [1:0] da_bit,
	input wire logic [3:0] da_wdata,
	// Mode and bank status.
	output logic [3:0] stack_bank_select_q,
	output logic legacy_addressing_mode,
	output logic [1:0] stack_bank,
	output logic memory_bank_enable_flag_q,
	output logic [3:0] memory_bank_select_q,
	// Register pair read.
	output logic [7:0] rp_rdata_q,
	// Program address results.
	output logic [14:0] pc_q,
	output logic pa_ack_q,
	output logic pa_err_q,
	// Data address results.
	output logic da_ack_q,
	output logic da_err_q,
	output logic [3:0] active_memory_bank_q,
	output logic [7:0] dm_offset_q,
	output logic dm_gpr_q,
	output logic [3:0] dm_bit_mask_q,
	output logic [3:0] da_rdata,
	// Peripheral area access.
	output logic per_req_q,
	output logic per_we_q,
	output logic [7:0] per_addr_q,
	output logic [3:0] per_wdata_q
);
	import cmag_pkg::*;

	// ****************************************
	// Functions
	// ****************************************

	// Picks the bank from the enable flag: select value or the default the caller passes in.
	function automatic logic [3:0] cmag_sel_bank(
		input logic memory_bank_enable_flag,
		input logic [3:0] memory_bank_select,
		input logic [3:0] dflt
	);
		cmag_sel_bank = memory_bank_enable_flag ? memory_bank_select : dflt;
	endfunction : cmag_sel_bank

	// ****************************************
	// Reset and RAM
	// ****************************************
	logic rst_n; // Synchronised reset used everywhere below.
	cmag_ram_if ram_if (); // Link to the data RAM.

	// Reset release through two flops.
	cmag_rst_sync u_rst_sync (
		.clk(core_clk),
		.nrst(nrst),
		.rst_n(rst_n)
	);

	// Data area RAM, banks 0 to 3.
	cmag_ram #(
		.DEPTH(RAM_DEPTH)
	) u_ram (
		.clk(core_clk),
		.rst_n(rst_n),
		.bus(ram_if.mem)
	);

	// ****************************************
	// Mode and bank registers
	// ****************************************
	logic mbs_ok; // Select value is one of 0-3 or 15.
	logic legacy; // Legacy addressing in force.

	assign mbs_ok = (mbs_wdata[3:2] == 2'b00) || (mbs_wdata == BANK_SYS);
	assign legacy = stack_bank_select_q[SBS_MODE_BIT];
	assign legacy_addressing_mode = legacy;
	assign stack_bank = stack_bank_select_q[1:0]; // RQ6

	// Mode register; the mode bit comes up set.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stack_bank_select_q <= SBS_RST; // RQ20
		end else if (sbs_wr) begin
			stack_bank_select_q <= sbs_wdata; // RQ1
		end
	end

	// Bank enable flag and select; other select values are ignored.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			memory_bank_enable_flag_q <= 1'b0;
			memory_bank_select_q <= BANK_RAM0;
		end else begin
			if (mbe_wr) begin
				memory_bank_enable_flag_q <= mbe_wdata;
			end
			if (mbs_wr && mbs_ok) begin
				memory_bank_select_q <= mbs_wdata;
			end
		end
	end

	// ****************************************
	// Data address decode
	// ****************************************
	logic [3:0] dk_bank; // Bank the request lands in.
	logic [7:0] dk_off; // Word offset inside the bank.
	logic dk_err; // Operand out of its legal range.
	logic dk_inc; // Post-increment of L.
	logic dk_dec; // Post-decrement of L.
	logic [7:0] hl_pair; // Primary pointer.
	logic [7:0] de_pair; // Secondary pointer.
	logic [3:0] direct_dflt; // Bank for direct operands with flag clear.
	logic fmem_ok; // Short bit operand in range.
	logic da_go; // Request accepted.
	logic dk_ram; // Target lies in the RAM banks.
	logic dk_sys; // Target lies in the peripheral bank.

	assign direct_dflt = (da_operand[7:0] < DIRECT_SPLIT) ? BANK_RAM0 : BANK_SYS; // RQ7
	assign fmem_ok = ((da_operand >= FMEM_A_LO) && (da_operand <= FMEM_A_HI))
		|| (da_operand >= FMEM_B_LO); // RQ9

	// Bank, offset and legality per operand kind.
	always_comb begin
		dk_bank = BANK_RAM0;
		dk_off = da_operand[7:0];
		dk_err = 1'b0;
		dk_inc = 1'b0;
		dk_dec = 1'b0;
		case (da_kind)
			DK_DIRECT, DK_DIRECT8: begin
				// Flag clear splits the 8-bit operand over banks 0 and 15.
				dk_bank = cmag_sel_bank(memory_bank_enable_flag_q,
					memory_bank_select_q, direct_dflt); // RQ7
				dk_err = (da_kind == DK_DIRECT8) && da_operand[0]; // RQ15
			end
			DK_FMEM: begin
				// Always bank 15, whatever the flag.
				dk_bank = BANK_SYS; // RQ9
				dk_err = !fmem_ok; // RQ9
			end
			DK_PMEM: begin
				// Always bank 15, whatever the flag.
				dk_bank = BANK_SYS; // RQ10
				dk_err = (da_operand < PMEM_LO); // RQ10
			end
			DK_HL, DK_HL_INC, DK_HL_DEC: begin
				// Primary pointer with optional step of L afterwards.
				dk_bank = cmag_sel_bank(memory_bank_enable_flag_q,
					memory_bank_select_q, BANK_RAM0); // RQ18
				dk_off = hl_pair; // RQ18
				dk_inc = (da_kind == DK_HL_INC); // RQ18
				dk_dec = (da_kind == DK_HL_DEC); // RQ18
			end
			DK_SEC_DE: begin
				// Secondary pointers never leave bank 0.
				dk_bank = BANK_RAM0; // RQ8
				dk_off = de_pair; // RQ18
			end
			DK_SEC_DL: begin
				// D supplies the high nibble, L the low one.
				dk_bank = BANK_RAM0; // RQ8
				dk_off = {de_pair[7:4], hl_pair[3:0]}; // RQ18
			end
			default: begin
				// Unknown kinds are refused.
				dk_err = 1'b1;
			end
		endcase
	end

	assign da_go = da_req && !dk_err;
	assign dk_ram = (dk_bank[3:2] == 2'b00); // RQ4
	assign dk_sys = (dk_bank == BANK_SYS);

	// RAM drive: bank in the top two index bits, offset below.
	assign ram_if.en = da_go && dk_ram; // RQ4
	assign ram_if.we = da_we;
	assign ram_if.addr = {dk_bank[1:0], dk_off}; // RQ4
	assign ram_if.wdata = da_wdata;
	assign da_rdata = ram_if.rdata;

	// Registered results of a data request.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			da_ack_q <= 1'b0;
			da_err_q <= 1'b0;
			active_memory_bank_q <= BANK_RAM0;
			dm_offset_q <= 8'h00;
			dm_gpr_q <= 1'b0;
			dm_bit_mask_q <= 4'h0;
		end else begin
			da_ack_q <= da_req;
			da_err_q <= da_req && dk_err;
			if (da_go) begin
				active_memory_bank_q <= dk_bank; // RQ7
				dm_offset_q <= dk_off;
				dm_gpr_q <= (dk_bank == BANK_RAM0) && (dk_off <= GPR_MAX); // RQ5
				dm_bit_mask_q <= 4'h1 << da_bit; // RQ19
			end
		end
	end

	// Peripheral area strobe for bank 15 targets.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			per_req_q <= 1'b0;
			per_we_q <= 1'b0;
			per_addr_q <= 8'h00;
			per_wdata_q <= 4'h0;
		end else begin
			per_req_q <= da_go && dk_sys;
			if (da_go && dk_sys) begin
				per_we_q <= da_we;
				per_addr_q <= dk_off;
				per_wdata_q <= da_wdata;
			end
		end
	end

	// ****************************************
	// Register pairs
	// ****************************************
	logic [7:0] pair_q [NUM_PAIRS]; // Primary 0-3, alternates 4-7.
	logic [3:0] l_next; // Stepped L nibble.
	logic l_step; // L is stepped this cycle.

	assign hl_pair = pair_q[PAIR_HL];
	assign de_pair = pair_q[PAIR_DE];
	assign l_step = da_go && (dk_inc || dk_dec);
	assign l_next = dk_inc ? (hl_pair[3:0] + 4'h1) : (hl_pair[3:0] - 4'h1);

	// One register per pair; a direct write beats the pointer step.
	for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
		logic wr_hit; // This pair is written.
		assign wr_hit = rp_wr && (rp_wsel == 3'(g));
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				pair_q[g] <= 8'h00;
			end else if (wr_hit) begin
				pair_q[g] <= rp_wdata; // RQ17
			end else if (l_step && (3'(g) == PAIR_HL)) begin
				pair_q[g] <= {pair_q[g][7:4], l_next}; // RQ18
			end
		end
	end

	// Registered read of any pair.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rp_rdata_q <= 8'h00;
		end else begin
			rp_rdata_q <= pair_q[rp_rsel]; // RQ17
		end
	end

	// ****************************************
	// Program address generation
	// ****************************************
	logic [14:0] pk_tgt; // Raw target of the request.
	logic pk_err; // Kind-specific range fault.
	logic signed [15:0] rel_diff; // Target minus current PC.
	logic rel_ok; // Relative target inside its window.
	logic pa_err; // Any fault on this request.
	logic [14:0] pc_d; // Next PC.

	assign rel_diff = $signed({1'b0, pa_operand}) - $signed({1'b0, pc_q});
	assign rel_ok = ((rel_diff >= REL_BACK_LO) && (rel_diff <= REL_BACK_HI))
		|| ((rel_diff >= REL_FWD_LO) && (rel_diff <= REL_FWD_HI)); // RQ11

	// Target and legality per kind.
	always_comb begin
		pk_tgt = pa_operand;
		pk_err = 1'b0;
		case (pa_kind)
			PK_SEQ: begin
				// Plain step; the legacy mask wraps it.
				pk_tgt = pc_q + 15'h0001;
			end
			PK_ABS: begin
				// Ordinary absolute, also used for 14-bit vectors.
				pk_err = (pa_operand > PC_LEGACY_MAX); // RQ16 RQ2
			end
			PK_EXT_ABS: begin
				// Whole space, extended mode only.
				pk_err = legacy; // RQ16
			end
			PK_REL: begin
				// Short hop around the current PC.
				pk_err = !rel_ok; // RQ11
			end
			PK_PAGE: begin
				// Keep the page, replace twelve bits.
				pk_tgt = {pc_q[14:12], pa_operand[11:0]}; // RQ12
				pk_err = (pk_tgt > PAGE_TOP_MAX); // RQ12
			end
			PK_SCALL: begin
				// Eleven-bit target in the lowest 2K.
				pk_tgt = {4'h0, pa_operand[10:0]}; // RQ13
				pk_err = (pa_operand > SCALL_MAX); // RQ13
			end
			PK_TCALL: begin
				// Even table entry in 20H-7FH.
				pk_err = (pa_operand < TCALL_MIN) || (pa_operand > TCALL_MAX)
					|| pa_operand[0]; // RQ14
			end
			PK_PAGE_IND: begin
				// Only the low byte moves.
				pk_tgt = {pc_q[14:8], pa_operand[7:0]}; // RQ3
			end
			default: begin
				// All kinds are listed; hold the PC otherwise.
				pk_tgt = pc_q;
			end
		endcase
	end

	// Legacy mode refuses any target above 3FFFH except a wrapping step.
	assign pa_err = pk_err || (legacy && pk_tgt[14] && (pa_kind != PK_SEQ)); // RQ1 RQ12
	assign pc_d = legacy ? {1'b0, pk_tgt[13:0]} : pk_tgt; // RQ21

	// PC update; bit 14 is cleared whenever legacy mode holds.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= PC_RST;
			pa_ack_q <= 1'b0;
			pa_err_q <= 1'b0;
		end else begin
			pa_ack_q <= pa_req;
			pa_err_q <= pa_req && pa_err;
			if (pa_req && !pa_err) begin
				pc_q <= pc_d; // RQ1
			end else if (legacy) begin
				pc_q[14] <= 1'b0; // RQ21
			end
		end
	end

endmodule : cmag_top
`default_nettype wire

// >>> cmag_pkg.sv
// Shared constants and operand kinds of the core address generation block.
//
// Notes on behaviour
// RQ1: Legacy mode 0000H-3FFFH, extended mode 0000H-7FFFH.
// RQ2: Software keeps interrupt vectors below 4000H.
// RQ3: Page indirect jump replaces PC bits 7:0.
// RQ4: Data area is 1024 four-bit RAM words.
// RQ5: Words 000H-01FH form the register area.
// RQ6: Banks 0 to 3 selectable as stack.
// RQ7: Direct operands bank by enable flag, select.
// RQ8: Secondary pointer pairs always use bank 0.
// RQ9: Short bit operands FB0H-FBFH, FF0H-FFFH, bank 15.
// RQ10: Peripheral bit operands FC0H-FFFH, bank 15.
// RQ11: Relative targets PC-15..PC-1 or PC+2..PC+16.
// RQ12: Page call keeps PC 14:12, top ends 7F7FH.
// RQ13: Short call targets 0000H-07FFH only.
// RQ14: Table call operand 20H-7FH, even only.
// RQ15: Eight-bit direct operands need even addresses.
// RQ16: Extended absolute targets only in extended mode.
// RQ17: Four primary and four alternate register pairs.
// RQ18: HL plain, HL+, HL-, DE and DL pointers.
// RQ19: Bit operand selects one of four bits.
// RQ20: Mode bit resets to one, legacy mode.
// RQ21: Legacy mode holds PC bit 14 at zero.
package cmag_pkg;

	// ****************************************
	// Mode register
	// ****************************************
	localparam logic [3:0] SBS_RST = 4'h8; // Mode bit set, stack bank 0.
	localparam int SBS_MODE_BIT = 3; // Set means legacy addressing.

	// ****************************************
	// Program memory limits
	// ****************************************
	localparam logic [14:0] PC_RST = 15'h0000;
	localparam logic [14:0] PC_LEGACY_MAX = 15'h3FFF;
	localparam logic [14:0] PAGE_TOP_MAX = 15'h7F7F;
	localparam logic [14:0] SCALL_MAX = 15'h07FF;
	localparam logic [14:0] TCALL_MIN = 15'h0020;
	localparam logic [14:0] TCALL_MAX = 15'h007F;
	localparam logic signed [15:0] REL_BACK_LO = 16'shFFF1; // Minus 15.
	localparam logic signed [15:0] REL_BACK_HI = 16'shFFFF; // Minus 1.
	localparam logic signed [15:0] REL_FWD_LO = 16'sh0002;
	localparam logic signed [15:0] REL_FWD_HI = 16'sh0010;

	// ****************************************
	// Data memory layout
	// ****************************************
	localparam logic [3:0] BANK_RAM0 = 4'h0;
	localparam logic [3:0] BANK_SYS = 4'hF;
	localparam logic [7:0] DIRECT_SPLIT = 8'h80;
	localparam logic [7:0] GPR_MAX = 8'h1F;
	localparam logic [11:0] FMEM_A_LO = 12'hFB0;
	localparam logic [11:0] FMEM_A_HI = 12'hFBF;
	localparam logic [11:0] FMEM_B_LO = 12'hFF0;
	localparam logic [11:0] PMEM_LO = 12'hFC0;
	localparam int RAM_DEPTH = 1024;
	localparam int RAM_AW = 10;
	localparam int RAM_DW = 4;
	localparam int NUM_PAIRS = 8;
	localparam logic [2:0] PAIR_DE = 3'h2;
	localparam logic [2:0] PAIR_HL = 3'h3;

	// ****************************************
	// Operand kinds
	// ****************************************
	typedef enum logic [2:0] {
		PK_SEQ = 3'h0, PK_ABS = 3'h1, PK_EXT_ABS = 3'h2, PK_REL = 3'h3,
		PK_PAGE = 3'h4, PK_SCALL = 3'h5, PK_TCALL = 3'h6, PK_PAGE_IND = 3'h7
	} cmag_pkind_t;

	typedef enum logic [3:0] {
		DK_DIRECT = 4'h0, DK_DIRECT8 = 4'h1, DK_FMEM = 4'h2, DK_PMEM = 4'h3,
		DK_HL = 4'h4, DK_HL_INC = 4'h5, DK_HL_DEC = 4'h6, DK_SEC_DE = 4'h7,
		DK_SEC_DL = 4'h8
	} cmag_dkind_t;

endpackage : cmag_pkg

// >>> cmag_ram_if.sv
// Interface joining the address logic to the data RAM.
`timescale 1ns/10ps
`default_nettype none
interface cmag_ram_if;
	logic en; // Access strobe.
	logic we; // Write when set.
	logic [9:0] addr; // Word index.
	logic [3:0] wdata; // Write nibble.
	logic [3:0] rdata; // Registered read nibble.
	modport ctrl (output en, output we, output addr, output wdata, input rdata);
	modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : cmag_ram_if
`default_nettype wire

// >>> cmag_rst_sync.sv
// Two-stage release of the asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module cmag_rst_sync (
	// Clock and raw reset.
	input wire logic clk,
	input wire logic nrst,
	// Synchronised reset.
	output logic rst_n
);
	logic meta_q; // First stage, read only by the second.

	// Assert at once, release after two edges.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			meta_q <= 1'b1;
			rst_n <= meta_q;
		end
	end
endmodule : cmag_rst_sync
`default_nettype wire

// >>> cmag_ram.sv
// Data area RAM with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module cmag_ram #(
	parameter int DEPTH = 1024
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Access port.
	cmag_ram_if.mem bus
);
	logic [3:0] mem_q [DEPTH]; // Storage words.

	// Write then read through one port; read data held in a flop.
	always_ff @(posedge clk) begin
		if (bus.en && bus.we) begin
			mem_q[bus.addr] <= bus.wdata;
		end
	end

	// Read register resets so the output is defined from reset on.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.rdata <= 4'h0;
		end else if (bus.en) begin
			bus.rdata <= bus.we ? bus.wdata : mem_q[bus.addr];
		end
	end
endmodule : cmag_ram
`default_nettype wire

// >>> cmag_props.sv
// Concurrent checks on the ports of the address generation block.
`timescale 1ns/10ps
`default_nettype none
module cmag_props (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Control inputs.
	input wire logic mbs_wr,
	input wire logic [3:0] mbs_wdata,
	input wire logic pa_req,
	input wire cmag_pkg::cmag_pkind_t pa_kind,
	input wire logic [14:0] pa_operand,
	input wire logic da_req,
	input wire cmag_pkg::cmag_dkind_t da_kind,
	input wire logic [11:0] da_operand,
	// Results.
	input wire logic legacy_addressing_mode,
	input wire logic [3:0] memory_bank_select_q,
	input wire logic [14:0] pc_q,
	input wire logic pa_ack_q,
	input wire logic pa_err_q,
	input wire logic da_ack_q,
	input wire logic da_err_q,
	input wire logic [3:0] active_memory_bank_q,
	input wire logic [7:0] dm_offset_q,
	input wire logic dm_gpr_q,
	input wire logic per_req_q
);
	import cmag_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// A refused program request answers with both pulses.
	sequence refused_s;
		pa_ack_q && pa_err_q;
	endsequence
	abs_range_a: assert property (pa_req && pa_kind == PK_ABS |=> pa_ack_q &&
		pa_err_q == ($past(pa_operand) > 15'h3FFF)) else $error("abs range");
	ext_legacy_a: assert property (pa_req && pa_kind == PK_EXT_ABS && legacy_addressing_mode
		|=> refused_s ##0 $stable(pc_q)) else $error("ext target in legacy");
	page_jump_a: assert property (pa_req && pa_kind == PK_PAGE_IND |=> pc_q ==
		(($past(pc_q) & 15'h7F00) | ($past(pa_operand) & 15'h00FF))) else $error("page jump");
	short_call_a: assert property (pa_req && pa_kind == PK_SCALL && pa_operand <= 15'h07FF
		|=> !pa_err_q && pc_q == $past(pa_operand)) else $error("short call");
	table_call_a: assert property (pa_req && pa_kind == PK_TCALL |=> pa_err_q ==
		($past(pa_operand) < 15'h0020 || $past(pa_operand) > 15'h007F ||
		($past(pa_operand) & 15'h0001) != 15'h0000)) else $error("table call");
	pc_top_a: assert property ($past(legacy_addressing_mode) |-> !pc_q[14])
		else $error("pc top bit");
	bank_keep_a: assert property (mbs_wr && mbs_wdata inside {[4:14]}
		|=> $stable(memory_bank_select_q)) else $error("bank select");
	sec_bank_a: assert property (da_req && (da_kind == DK_SEC_DE || da_kind == DK_SEC_DL)
		|=> da_ack_q && active_memory_bank_q == 4'h0) else $error("pointer bank");
	short_bit_a: assert property (da_req && da_kind == DK_FMEM && da_operand inside
		{[12'hFB0:12'hFBF], [12'hFF0:12'hFFF]} |=> !da_err_q && per_req_q &&
		active_memory_bank_q == 4'hF) else $error("short bit area");
	per_low_a: assert property (da_req && da_kind == DK_PMEM && da_operand < 12'hFC0
		|=> da_err_q && !per_req_q) else $error("peripheral bit area");
	gpr_area_a: assert property (da_ack_q && !da_err_q |-> dm_gpr_q ==
		(active_memory_bank_q == 4'h0 && dm_offset_q <= 8'h1F)) else $error("register area");
endmodule : cmag_props
bind cmag_top cmag_props chk (.core_clk, .nrst, .mbs_wr, .mbs_wdata, .pa_req, .pa_kind,
	.pa_operand, .da_req, .da_kind, .da_operand, .legacy_addressing_mode,
	.memory_bank_select_q, .pc_q, .pa_ack_q, .pa_err_q, .da_ack_q, .da_err_q,
	.active_memory_bank_q, .dm_offset_q, .dm_gpr_q, .per_req_q);
`default_nettype wire

// >>> cmag_per_model.sv
// Peripheral area stand-in that records bank-15 accesses.
`timescale 1ns/10ps
`default_nettype none
module cmag_per_model (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Access from the block.
	input wire logic per_req_q,
	input wire logic per_we_q,
	input wire logic [7:0] per_addr_q,
	input wire logic [3:0] per_wdata_q,
	// Access count.
	output logic [7:0] hits_q
);
	logic [3:0] store [256]; // Peripheral nibbles, left unreset like real latches.
	// Count every access and keep written nibbles for the bench to inspect.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hits_q <= 8'h00;
		end else if (per_req_q) begin
			hits_q <= hits_q + 8'h01;
			if (per_we_q) begin
				store[per_addr_q] <= per_wdata_q;
			end
		end
	end
endmodule : cmag_per_model
`default_nettype wire

// >>> test_cmag_top.sv
// Directed bench for the address generation block.
`timescale 1ns/10ps
`default_nettype none
module test_cmag_top;
	import cmag_pkg::*;
	logic core_clk = 1'b0;
	logic nrst, sbs_wr, mbe_wr, mbe_wdata, mbs_wr, rp_wr, pa_req, da_req, da_we;
	logic [3:0] sbs_wdata, mbs_wdata, da_wdata, stack_bank_select_q, memory_bank_select_q;
	logic [3:0] active_memory_bank_q, dm_bit_mask_q, da_rdata, per_wdata_q;
	logic [2:0] rp_wsel, rp_rsel;
	logic [7:0] rp_wdata, rp_rdata_q, dm_offset_q, per_addr_q, hits_q;
	logic [14:0] pa_operand, pc_q;
	logic [11:0] da_operand;
	logic [1:0] da_bit, stack_bank;
	logic legacy_addressing_mode, memory_bank_enable_flag_q, pa_ack_q, pa_err_q;
	logic da_ack_q, da_err_q, dm_gpr_q, per_req_q, per_we_q;
	cmag_pkind_t pa_kind;
	cmag_dkind_t da_kind;
	int num_errors = 0;
	int cmp_count = 0;
	int i;
	logic [11:0] fm [7] = '{12'hFAF, 12'hFB0, 12'hFBF, 12'hFC0, 12'hFEF, 12'hFF0, 12'hFFF};
	cmag_top uut (.core_clk, .nrst, .sbs_wr, .sbs_wdata, .mbe_wr, .mbe_wdata, .mbs_wr,
		.mbs_wdata, .rp_wr, .rp_wsel, .rp_wdata, .rp_rsel, .pa_req, .pa_kind, .pa_operand,
		.da_req, .da_kind, .da_we, .da_operand, .da_bit, .da_wdata, .stack_bank_select_q,
		.legacy_addressing_mode, .stack_bank, .memory_bank_enable_flag_q,
		.memory_bank_select_q, .rp_rdata_q, .pc_q, .pa_ack_q, .pa_err_q, .da_ack_q,
		.da_err_q, .active_memory_bank_q, .dm_offset_q, .dm_gpr_q, .dm_bit_mask_q,
		.da_rdata, .per_req_q, .per_we_q, .per_addr_q, .per_wdata_q);
	cmag_per_model per (.core_clk, .nrst, .per_req_q, .per_we_q, .per_addr_q,
		.per_wdata_q, .hits_q);
	// The clock toggles every half period of 10 ns.
	always #10 core_clk = ~core_clk;
	// Compare one value and count the outcome.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Print the verdict and stop.
	task automatic conclude;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	// One control write: 0 mode, 1 flag, 2 select, 3 pair.
	task automatic wr(input int k, input logic [7:0] v, input logic [2:0] s);
		@(negedge core_clk);
		{sbs_wr, mbe_wr, mbs_wr, rp_wr} = 4'h8 >> k;
		sbs_wdata = v[3:0];
		mbe_wdata = v[0];
		mbs_wdata = v[3:0];
		rp_wdata = v;
		rp_wsel = s;
		@(negedge core_clk);
		{sbs_wr, mbe_wr, mbs_wr, rp_wr} = 4'h0;
	endtask : wr
	// One program request with its expected refusal.
	task automatic pa(input cmag_pkind_t k, input logic [14:0] op, input logic err);
		@(negedge core_clk);
		pa_req = 1'b1;
		pa_kind = k;
		pa_operand = op;
		@(negedge core_clk);
		pa_req = 1'b0;
		chk(pa_ack_q, 1'b1);
		chk(pa_err_q, err);
	endtask : pa
	// One data request with its expected refusal.
	task automatic da(input cmag_dkind_t k, input logic [11:0] op, input logic we,
		input logic [3:0] wd, input logic err);
		@(negedge core_clk);
		da_req = 1'b1;
		da_kind = k;
		da_operand = op;
		da_we = we;
		da_wdata = wd;
		@(negedge core_clk);
		da_req = 1'b0;
		chk(da_ack_q, 1'b1);
		chk(da_err_q, err);
	endtask : da
	// Read one register pair back.
	task automatic pair_rd(input logic [2:0] s, input logic [7:0] e);
		@(negedge core_clk);
		rp_rsel = s;
		@(negedge core_clk);
		chk(rp_rdata_q, e);
	endtask : pair_rd
	// Cut a hang short well beyond the expected run.
	initial begin
		repeat (5000) @(posedge core_clk);
		num_errors++;
		conclude();
	end
	// Main sequence.
	initial begin
		nrst = 1'b0;
		{sbs_wr, mbe_wr, mbe_wdata, mbs_wr, rp_wr, pa_req, da_req, da_we} = 8'h00;
		{sbs_wdata, mbs_wdata, da_wdata, rp_wsel, rp_rsel, rp_wdata} = 26'h0;
		{pa_operand, da_operand, da_bit} = 29'h0;
		pa_kind = PK_SEQ;
		da_kind = DK_DIRECT;
		repeat (8) @(negedge core_clk);
		nrst = 1'b1;
		repeat (3) @(negedge core_clk);
		chk({stack_bank_select_q, legacy_addressing_mode}, {4'h8, 1'b1});
		pa(PK_ABS, 15'h3FFF, 1'b0);
		pa(PK_SEQ, 15'h0000, 1'b0);
		chk(pc_q, 15'h0000);
		pa(PK_ABS, 15'h4000, 1'b1);
		pa(PK_EXT_ABS, 15'h2000, 1'b1);
		pa(PK_ABS, 15'h0100, 1'b0);
		pa(PK_PAGE_IND, 15'h7F42, 1'b0);
		chk(pc_q, 15'h0142);
		for (i = -16; i <= 17; i++) begin
			pa(PK_ABS, 15'h0200, 1'b0);
			pa(PK_REL, 15'(512 + i), !((i >= -15 && i <= -1) || (i >= 2 && i <= 16)));
		end
		pa(PK_ABS, 15'h1234, 1'b0);
		pa(PK_PAGE, 15'h0ABC, 1'b0);
		chk(pc_q, 15'h1ABC);
		pa(PK_SCALL, 15'h0800, 1'b1);
		pa(PK_SCALL, 15'h07FF, 1'b0);
		for (i = 30; i <= 130; i++) begin
			pa(PK_TCALL, 15'(i), i[0] || i < 32 || i > 127);
		end
		for (i = 0; i < 4; i++) begin
			wr(0, 8'(i), 3'h0);
			chk({legacy_addressing_mode, stack_bank}, {1'b0, 2'(i)});
		end
		pa(PK_EXT_ABS, 15'h7000, 1'b0);
		pa(PK_PAGE, 15'h0F7F, 1'b0);
		chk(pc_q, 15'h7F7F);
		pa(PK_PAGE, 15'h0F80, 1'b1);
		pa(PK_ABS, 15'h4000, 1'b1);
		pa(PK_EXT_ABS, 15'h7FFF, 1'b0);
		wr(0, 8'h08, 3'h0);
		@(negedge core_clk);
		chk(pc_q[14], 1'b0);
		wr(1, 8'h00, 3'h0);
		da(DK_DIRECT, 12'h010, 1'b1, 4'h5, 1'b0);
		da(DK_DIRECT, 12'h010, 1'b0, 4'h0, 1'b0);
		chk({da_rdata, active_memory_bank_q, dm_offset_q}, {4'h5, 4'h0, 8'h10});
		chk(dm_gpr_q, 1'b1);
		da(DK_DIRECT, 12'h090, 1'b1, 4'hC, 1'b0);
		chk({active_memory_bank_q, per_req_q}, {4'hF, 1'b1});
		wr(1, 8'h01, 3'h0);
		wr(2, 8'h02, 3'h0);
		wr(2, 8'h05, 3'h0);
		chk(memory_bank_select_q, 4'h2);
		chk(memory_bank_enable_flag_q, 1'b1);
		da(DK_DIRECT, 12'h010, 1'b1, 4'hA, 1'b0);
		chk({active_memory_bank_q, dm_gpr_q}, {4'h2, 1'b0});
		wr(3, 8'h10, PAIR_DE);
		da(DK_SEC_DE, 12'h000, 1'b0, 4'h0, 1'b0);
		chk({active_memory_bank_q, da_rdata}, {4'h0, 4'h5});
		da(DK_SEC_DL, 12'h000, 1'b0, 4'h0, 1'b0);
		chk({active_memory_bank_q, da_rdata}, {4'h0, 4'h5});
		wr(3, 8'h1F, PAIR_HL);
		da(DK_HL, 12'h000, 1'b0, 4'h0, 1'b0);
		chk({active_memory_bank_q, dm_offset_q}, {4'h2, 8'h1F});
		da(DK_HL_INC, 12'h000, 1'b0, 4'h0, 1'b0);
		pair_rd(PAIR_HL, 8'h10);
		da(DK_HL_DEC, 12'h000, 1'b0, 4'h0, 1'b0);
		pair_rd(PAIR_HL, 8'h1F);
		wr(2, 8'h0F, 3'h0);
		da(DK_DIRECT, 12'h0F5, 1'b1, 4'h3, 1'b0);
		da(DK_DIRECT8, 12'h011, 1'b0, 4'h0, 1'b1);
		da(DK_DIRECT8, 12'h012, 1'b0, 4'h0, 1'b0);
		for (i = 0; i < 7; i++) begin
			da(DK_FMEM, fm[i], 1'b0, 4'h0, !(fm[i] inside {[12'hFB0:12'hFBF], [12'hFF0:12'hFFF]}));
		end
		da(DK_PMEM, 12'hFBF, 1'b0, 4'h0, 1'b1);
		da(DK_PMEM, 12'hFC0, 1'b0, 4'h0, 1'b0);
		chk(active_memory_bank_q, 4'hF);
		chk({per.store[8'hF5], per.store[8'h90]}, 8'h3C);
		da(cmag_dkind_t'(4'h9), 12'h000, 1'b0, 4'h0, 1'b1);
		for (i = 0; i < 4; i++) begin
			da_bit = 2'(i);
			da(DK_DIRECT, 12'h020, 1'b0, 4'h0, 1'b0);
			chk(dm_bit_mask_q, 4'h1 << i);
		end
		for (i = 0; i < 8; i++) begin
			wr(3, 8'(i * 17 + 3), 3'(i));
		end
		for (i = 0; i < 8; i++) begin
			pair_rd(3'(i), 8'(i * 17 + 3));
		end
		chk(hits_q, 8'h0C);
		conclude();
	end
endmodule : test_cmag_top
`default_nettype wire
